/* File: can_msg_fifo_depth_irq.v */
// Message FIFOs of a CAN FD controller with depth selection and interrupt generation.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "can_msg_fifo_regs.vh"
// What this block does
// R01 - Eight shared receive FIFOs, 128 messages each
// R02 - Receive depth only 0,4,8,16,32,48,64,128
// R03 - Receive depth code 000 disables, 001 four
// R04 - Mode 0 interrupts at eighth threshold or full
// R05 - Mode 1 interrupts on every stored message
// R06 - Software avoids 1/8 threshold at depth four
// R07 - Full interrupt when enabled and FIFO fills
// R08 - Disable keeps full flag; software writes zero
// R09 - Three transmit/receive FIFOs, same depth set
// R10 - Transmit/receive depth code 000 means unused
// R11 - Interval and link only in transmit/gateway
// R12 - Threshold code 000..110 eighths, 111 full
// R13 - Receive mode 1 interrupts every reception
// R14 - One-frame interrupt on each frame received in receive mode
// R15 - Transmit completion feeds channel transmit interrupt
// R16 - Threshold checked on store, single-cycle pulse
module can_msg_fifo_depth_irq #(
    parameter NRX  = 8,
    parameter NTRX = 3,
    parameter NF   = 11,
    parameter MAXD = 128,
    parameter DW   = 32
) (
    // Clock and reset
    input  wire               clk_i,
    input  wire               srst_i,
    // APB slave
    input  wire               psel_i,
    input  wire               penable_i,
    input  wire               pwrite_i,
    input  wire [11:0]        paddr_i,
    input  wire [31:0]        pwdata_i,
    output wire               pready_o,
    output reg  [31:0]        prdata_o,
    output wire               pslverr_o,
    // Received frames from the protocol controller
    input  wire               rx_valid_i,
    input  wire [3:0]         rx_sel_i,
    input  wire [DW-1:0]      rx_data_i,
    output wire               rx_ready_o,
    // Transmission completion per transmit/receive FIFO
    input  wire [NTRX-1:0]    tx_done_i,
    output reg                channel_tx_irq_o,
    // Event pulses and transmit settings
    output reg  [NF-1:0]      fifo_rx_irq_o,
    output reg  [NF-1:0]      fifo_full_irq_o,
    output reg  [NTRX-1:0]    one_frame_irq_o,
    output reg  [NTRX*8-1:0]  trx_interval_o,
    output reg  [NTRX*7-1:0]  trx_link_o,
    // Interrupt
    output wire               irq_o
);

    // Message buffers for each depth code.
    function [7:0] depth_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: depth_of = `DEPTH_C0;
                3'h1: depth_of = `DEPTH_C1;
                3'h2: depth_of = `DEPTH_C2;
                3'h3: depth_of = `DEPTH_C3;
                3'h4: depth_of = `DEPTH_C4;
                3'h5: depth_of = `DEPTH_C5;
                3'h6: depth_of = `DEPTH_C6;
                default: depth_of = `DEPTH_C7;
            endcase
        end
    endfunction

    // Per-FIFO state; the memory keeps 128 slots for every FIFO.
    reg  [31:0]       cfg_reg    [0:NF-1];
    reg  [6:0]        wptr_reg   [0:NF-1];
    reg  [6:0]        rptr_reg   [0:NF-1];
    reg  [7:0]        count_reg  [0:NF-1];
    reg               fflag_reg  [0:NF-1];
    reg  [DW-1:0]     mem        [0:NF*MAXD-1];
    wire [31:0]       sts_w      [0:NF-1];
    reg  [`IRQ_W-1:0] irq_sts_reg;
    reg  [`IRQ_W-1:0] irq_mask_reg;

    wire [NF-1:0]     acc_ok;
    wire [NF-1:0]     rx_evt;
    wire [NF-1:0]     full_evt;
    wire [NTRX-1:0]   of_evt;
    wire [NTRX-1:0]   txm;
    // Select guard and pop bookkeeping.
    reg               rx_ready_c;
    reg               pop_armed_reg;

    // APB decode: the FIFO number sits in address bits [5:2].
    wire        setup   = psel_i & ~penable_i;
    wire        access  = psel_i & penable_i;
    wire [3:0]  idx     = paddr_i[5:2];
    wire [11:0] region  = paddr_i & `REGION_MASK;
    wire        idx_ok  = (idx < NF);
    wire        cfg_hit = (region == `CFG_BASE) & idx_ok;
    wire        sts_hit = (region == `STS_BASE) & idx_ok;
    wire        dat_hit = (region == `DATA_BASE) & idx_ok;
    wire        ist_hit = (paddr_i == `IRQ_STS_ADDR);
    wire        imk_hit = (paddr_i == `IRQ_MASK_ADDR);
    wire        mapped  = cfg_hit | sts_hit | dat_hit | ist_hit | imk_hit;
    wire        wr_acc  = access & pwrite_i & mapped;
    wire        rd_acc  = access & ~pwrite_i & mapped;

    // Every access completes in its first access cycle.
    assign pready_o   = 1'b1;
    assign pslverr_o  = access & ~mapped;
    assign rx_ready_o = rx_ready_c;
    assign irq_o      = |(irq_sts_reg & irq_mask_reg);

    // An unused FIFO number on the select never indexes past the array.
    always @* begin
        rx_ready_c = 1'b0;
        if (rx_sel_i < NF) begin
            rx_ready_c = acc_ok[rx_sel_i];
        end
    end

    // Per-FIFO storage control, levels and events; the last NTRX FIFOs are the transmit/receive ones.
    genvar g;
    generate
        for (g = 0; g < NF; g = g + 1) begin : fifo
            localparam [3:0] ID  = g;
            localparam       TRX = (g >= NRX);

            wire [31:0] cfg   = cfg_reg[g];
            wire [7:0]  depth = depth_of(cfg[`CFG_DC_LSB+2:`CFG_DC_LSB]); // [R02] [R09]
            wire [1:0]  mode  = TRX ? cfg[`CFG_MD_LSB+1:`CFG_MD_LSB] : `MODE_RX;
            wire        rxm   = (mode == `MODE_RX);
            wire        en    = cfg[`CFG_EN_BIT];
            wire [7:0]  cnt   = count_reg[g];
            wire        full  = (cnt == depth);
            wire        store = rx_valid_i & (rx_sel_i == ID) & acc_ok[g];
            wire        pop   = rd_acc & dat_hit & (idx == ID) & pop_armed_reg & (cnt != 8'h0);
            wire [7:0]  cnt_nx = cnt + {7'h0, store} - {7'h0, pop};
            // The level is depth times (code + 1) over eight, rounded down; code 7 is full.
            // Depth four with code 0 gives level 0, which never matches, so software avoids it.
            wire [3:0]  th_p1 = {1'b0, cfg[`CFG_TH_LSB+2:`CFG_TH_LSB]} + 4'h1;
            wire [11:0] prod  = {4'h0, depth} * {8'h0, th_p1};
            wire [7:0]  lvl   = prod[10:3]; // [R12]
            wire [7:0]  wp1   = {1'b0, wptr_reg[g]} + 8'h1;
            wire [7:0]  rp1   = {1'b0, rptr_reg[g]} + 8'h1;
            // Pointers wrap at the programmed depth rather than at the slot count.
            wire [6:0]  wptr_next = (wp1 == depth) ? 7'h0 : wp1[6:0];
            wire [6:0]  rptr_next = (rp1 == depth) ? 7'h0 : rp1[6:0];
            wire        at_lvl    = (cnt_nx == lvl);
            wire        now_full  = (cnt_nx == depth);

            // A zero depth or a transmitting FIFO accepts no received frame.
            assign acc_ok[g] = en & (mode != `MODE_TX) & (depth != 8'h0) & ~full; // [R03] [R10]
            assign rx_evt[g] = store & rxm &
                               (cfg[`CFG_IM_BIT] | at_lvl); // [R04] [R05] [R13] [R16]
            assign full_evt[g] = store & now_full & cfg[`CFG_FIE_BIT]; // [R07]
            assign sts_w[g] = {21'h0, fflag_reg[g], full, (cnt == 8'h0), cnt};

            // Only the writable fields of each kind of FIFO are kept.
            always @(posedge clk_i) begin
                if (srst_i) begin
                    cfg_reg[g] <= `CFG_RST;
                end else if (wr_acc & cfg_hit & (idx == ID)) begin
                    cfg_reg[g] <= pwdata_i & (TRX ? `CFG_TRX_WMASK : `CFG_RX_WMASK);
                end
            end

            // Clearing the enable empties the FIFO at once.
            always @(posedge clk_i) begin
                if (srst_i | ~en) begin
                    wptr_reg[g]  <= 7'h0;
                    rptr_reg[g]  <= 7'h0;
                    count_reg[g] <= 8'h0;
                end else begin
                    count_reg[g] <= cnt_nx;
                    if (store) begin
                        wptr_reg[g] <= wptr_next;
                    end
                    if (pop) begin
                        rptr_reg[g] <= rptr_next;
                    end
                end
            end

            // The flag survives disabling; only a written zero clears it.
            // A full event in the same cycle as that write wins.
            always @(posedge clk_i) begin
                if (srst_i) begin
                    fflag_reg[g] <= 1'b0;
                end else if (full_evt[g]) begin
                    fflag_reg[g] <= 1'b1; // [R08]
                end else if (wr_acc & sts_hit & (idx == ID) & ~pwdata_i[`STS_FFLG_BIT]) begin
                    fflag_reg[g] <= 1'b0; // [R08]
                end
            end

            // Transmit/receive FIFOs only: one-frame event and transmit-only settings.
            if (TRX) begin : trx
                localparam T = g - NRX;
                assign of_evt[T] = store & rxm; // [R14]
                assign txm[T]    = (mode == `MODE_TX) | (mode == `MODE_GW);
                always @(posedge clk_i) begin
                    if (srst_i) begin
                        trx_interval_o[T*8 +: 8] <= 8'h0;
                        trx_link_o[T*7 +: 7]     <= 7'h0;
                    end else if (txm[T]) begin
                        trx_interval_o[T*8 +: 8] <= cfg[`CFG_IT_LSB +: 8]; // [R11]
                        trx_link_o[T*7 +: 7]     <= cfg[`CFG_LK_LSB +: 7]; // [R11]
                    end else begin
                        // Receive mode hides the transmit-only settings.
                        trx_interval_o[T*8 +: 8] <= 8'h0; // [R11]
                        trx_link_o[T*7 +: 7]     <= 7'h0; // [R11]
                    end
                end
            end
        end
    endgenerate

    // One shared array holds all FIFOs, 128 slots per FIFO.
    // Ready is only high for a select in range, so the write index stays inside the array.
    always @(posedge clk_i) begin
        if (rx_valid_i & rx_ready_o) begin
            mem[{rx_sel_i, wptr_reg[rx_sel_i]}] <= rx_data_i; // [R01]
        end
    end

    // Interrupt events, sticky status and outward pulses.
    wire [`IRQ_W-1:0] irq_set = {of_evt, full_evt, rx_evt};
    wire [`IRQ_W-1:0] irq_clr = (wr_acc & ist_hit) ? pwdata_i[`IRQ_W-1:0] : `IRQ_RST;
    // A new event wins over a clear written in the same cycle.

    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_sts_reg <= `IRQ_RST;
        end else begin
            irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
        end
    end

    // Mask bits only gate the interrupt line; status still collects events.
    always @(posedge clk_i) begin
        if (srst_i) begin
            irq_mask_reg <= `IRQ_RST;
        end else if (wr_acc & imk_hit) begin
            irq_mask_reg <= pwdata_i[`IRQ_W-1:0];
        end
    end

    // Pulses last one cycle, rising at the same edge that stores the frame or samples tx_done_i.
    always @(posedge clk_i) begin
        if (srst_i) begin
            fifo_rx_irq_o    <= {NF{1'b0}};
            fifo_full_irq_o  <= {NF{1'b0}};
            one_frame_irq_o  <= {NTRX{1'b0}};
            channel_tx_irq_o <= 1'b0;
        end else begin
            fifo_rx_irq_o    <= rx_evt; // [R16]
            fifo_full_irq_o  <= full_evt; // [R07]
            one_frame_irq_o  <= of_evt; // [R14]
            channel_tx_irq_o <= |(tx_done_i & txm); // [R15]
        end
    end

    // Read data is captured in the setup cycle; a data read pops at the access edge.
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0;
        if (cfg_hit) begin
            rd_mux = cfg_reg[idx];
        end else if (sts_hit) begin
            rd_mux = sts_w[idx];
        end else if (dat_hit) begin
            // An empty FIFO reads as zero and does not move.
            rd_mux = (count_reg[idx] != 8'h0) ? mem[{idx, rptr_reg[idx]}] : 32'h0;
        end else if (ist_hit) begin
            rd_mux = {7'h0, irq_sts_reg};
        end else if (imk_hit) begin
            rd_mux = {7'h0, irq_mask_reg};
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0;
        end else if (setup & ~pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    // A data read pops only a word that was already there at the setup edge,
    // so a frame stored between setup and access is not lost.
    always @(posedge clk_i) begin
        if (srst_i) begin
            pop_armed_reg <= 1'b0;
        end else if (setup) begin
            pop_armed_reg <= ~pwrite_i & dat_hit & (count_reg[idx] != 8'h0);
        end
    end

endmodule // can_msg_fifo_depth_irq

/* File: can_msg_fifo_depth_irq_assertions.sv */
// Port checker of the message FIFO block.
`timescale 1ns/1ps
module can_msg_fifo_checker #(
    parameter NTRX = 3,
    parameter NF   = 11
) (
    // Clock and reset
    input wire            clk_i,
    input wire            srst_i,
    // APB
    input wire            psel_i,
    input wire            penable_i,
    input wire [11:0]     paddr_i,
    input wire            pslverr_o,
    // Receive link and events
    input wire            rx_valid_i,
    input wire [3:0]      rx_sel_i,
    input wire            rx_ready_o,
    input wire [NTRX-1:0] tx_done_i,
    input wire            channel_tx_irq_o,
    input wire [NF-1:0]   fifo_rx_irq_o,
    input wire [NF-1:0]   fifo_full_irq_o,
    input wire [NTRX-1:0] one_frame_irq_o,
    input wire            irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_rx_cause: assert property (fifo_rx_irq_o != 0 |-> $past(rx_valid_i && rx_ready_o) &&
        fifo_rx_irq_o == (11'h1 << $past(rx_sel_i))) else $error("rx pulse without store");
    chk_rx_single: assert property ($onehot0(fifo_rx_irq_o) && $onehot0(fifo_full_irq_o))
        else $error("several pulses at once");
    chk_full_cause: assert property (fifo_full_irq_o != 0 |-> $past(rx_valid_i && rx_ready_o) &&
        fifo_full_irq_o == (11'h1 << $past(rx_sel_i))) else $error("full pulse without store");
    chk_full_refuse: assert property (fifo_full_irq_o[0] && rx_sel_i == 4'h0 |-> !rx_ready_o)
        else $error("full fifo ready");
    chk_one_frame: assert property (one_frame_irq_o != 0 |-> $past(rx_valid_i && rx_ready_o && rx_sel_i > 4'h7))
        else $error("one-frame without store");
    chk_tx_cause: assert property (channel_tx_irq_o |-> $past(tx_done_i != 0))
        else $error("tx irq without done");
    chk_slverr_map: assert property (psel_i && penable_i && paddr_i[11:6] == 6'h0 && paddr_i[1:0] == 2'h0
        |-> pslverr_o == (paddr_i[5:2] > 4'ha)) else $error("slave error wrong");
    chk_reset_quiet: assert property ($past(srst_i) |-> !irq_o && !rx_ready_o)
        else $error("not quiet after reset");
    cover property (fifo_rx_irq_o != 0);
    cover property (fifo_full_irq_o != 0);
    cover property (one_frame_irq_o != 0);
    cover property (channel_tx_irq_o);
endmodule // can_msg_fifo_checker
bind can_msg_fifo_depth_irq can_msg_fifo_checker #(.NTRX(NTRX), .NF(NF)) i_can_msg_fifo_checker (.clk_i, .srst_i,
    .psel_i, .penable_i, .paddr_i, .pslverr_o, .rx_valid_i, .rx_sel_i, .rx_ready_o, .tx_done_i,
    .channel_tx_irq_o, .fifo_rx_irq_o, .fifo_full_irq_o, .one_frame_irq_o, .irq_o);

/* File: can_msg_fifo_depth_irq_test.sv */
// Self-checking test of the message FIFO block.
`timescale 1ns/1ps
module can_msg_fifo_depth_irq_test;
    reg         clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, ok, er;
    reg  [11:0] paddr_i = 12'h000;
    reg  [31:0] pwdata_i = 32'h00000000, rd;
    wire        pready_o, pslverr_o, rx_valid_i, rx_ready_o, channel_tx_irq_o, irq_o;
    wire [31:0] prdata_o, rx_data_i;
    wire [3:0]  rx_sel_i;
    wire [2:0]  tx_done_i, one_frame_irq_o;
    wire [10:0] fifo_rx_irq_o, fifo_full_irq_o;
    wire [23:0] trx_interval_o;
    wire [20:0] trx_link_o;
    integer     miscompares = 0, checks_done = 0, cyc = 0, n_rx = 0, n_full = 0, n_one = 0, n_tx = 0, k;
    can_msg_fifo_depth_irq i_can_msg_fifo_depth_irq (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .rx_valid_i, .rx_sel_i, .rx_data_i, .rx_ready_o, .tx_done_i,
        .channel_tx_irq_o, .fifo_rx_irq_o, .fifo_full_irq_o, .one_frame_irq_o, .trx_interval_o, .trx_link_o, .irq_o);
    can_rx_partner i_can_rx_partner (.clk_i(clk_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
        .rx_sel_o(rx_sel_i), .rx_data_o(rx_data_i), .tx_done_o(tx_done_i));
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        n_rx = n_rx + $countones(fifo_rx_irq_o);
        n_full = n_full + $countones(fifo_full_irq_o);
        n_one = n_one + $countones(one_frame_irq_o);
        n_tx = n_tx + channel_tx_irq_o;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clk_i);
            penable_i <= 1'b1;
            @(posedge clk_i);
            while (pready_o !== 1'b1) @(posedge clk_i);
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            #1;
        end
    endtask
    task settle;
        begin
            repeat (3) @(posedge clk_i);
            #1;
        end
    endtask
    task sends(input [3:0] s, input integer m);
        for (k = 0; k < m; k = k + 1) i_can_rx_partner.send(s, 32'h00000a00 + k, ok);
    endtask
    task t_reset;
        begin
            apb(0, 12'h020, 0); chk("cfg8 reset", 0, rd);
            apb(0, 12'h0c0, 0); chk("irq reset", 0, rd);
            chk("pready", 1, pready_o);
            apb(0, 12'h02c, 0); chk("unmapped err", 1, er);
            $display("test reset done");
        end
    endtask
    task t_thresh;
        begin
            apb(1, 12'h000, 32'h00000315);
            n_rx = 0;
            n_full = 0;
            sends(4'h0, 4);
            settle;
            chk("rx irq", 1, n_rx);
            chk("full irq", 1, n_full);
            apb(0, 12'h040, 0); chk("status full", 32'h00000604, rd);
            apb(0, 12'h080, 0); chk("data", 32'h00000a00, rd);
            apb(0, 12'h0c0, 0); chk("irq status", 32'h00000801, rd);
            apb(1, 12'h0c4, 32'h00000801); chk("irq on", 1, irq_o);
            apb(1, 12'h0c0, 32'h00000801); chk("irq off", 0, irq_o);
            apb(1, 12'h000, 0);
            apb(0, 12'h040, 0); chk("flag kept", 32'h00000700, rd);
            apb(1, 12'h040, 0);
            apb(0, 12'h040, 0); chk("flag cleared", 32'h00000300, rd);
            $display("test threshold done");
        end
    endtask
    task t_mode1;
        begin
            apb(1, 12'h004, 32'h00000073);
            apb(1, 12'h008, 32'h00000001);
            n_rx = 0;
            sends(4'h1, 3);
            settle;
            chk("rx each", 3, n_rx);
            i_can_rx_partner.send(4'h2, 32'h0, ok);
            chk("depth zero taken", 0, ok);
            $display("test mode done");
        end
    endtask
    task t_trx;
        begin
            apb(1, 12'h020, 32'h00000721);
            n_rx = 0;
            n_one = 0;
            n_full = 0;
            sends(4'h8, 8);
            settle;
            chk("trx full level", 1, n_rx);
            chk("one frame", 8, n_one);
            chk("no full irq", 0, n_full);
            apb(1, 12'h024, 32'h335a1011);
            n_tx = 0;
            settle;
            chk("interval", 8'h5a, trx_interval_o[15:8]);
            chk("link", 7'h33, trx_link_o[13:7]);
            i_can_rx_partner.done(2'h1);
            settle;
            chk("tx irq", 1, n_tx);
            apb(1, 12'h024, 32'h335a0011);
            i_can_rx_partner.done(2'h1);
            settle;
            chk("rx mode interval", 0, trx_interval_o[15:8]);
            chk("rx mode tx irq", 1, n_tx);
            $display("test trx done");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset;
        t_thresh;
        t_mode1;
        t_trx;
        give_verdict;
    end
endmodule // can_msg_fifo_depth_irq_test

/* File: can_msg_fifo_regs.vh */
// Register offsets, field positions, reset values and codes of the message FIFO block.
`ifndef CAN_MSG_FIFO_REGS_VH
`define CAN_MSG_FIFO_REGS_VH

// Register regions; the FIFO index sits in address bits [5:2].
`define CFG_BASE      12'h000
`define STS_BASE      12'h040
`define DATA_BASE     12'h080
`define IRQ_STS_ADDR  12'h0c0
`define IRQ_MASK_ADDR 12'h0c4
`define REGION_MASK   12'hfc3

// Configuration register fields.
`define CFG_EN_BIT    0
`define CFG_IM_BIT    1
`define CFG_FIE_BIT   2
`define CFG_DC_LSB    4
`define CFG_TH_LSB    8
`define CFG_MD_LSB    12
`define CFG_IT_LSB    16
`define CFG_LK_LSB    24
`define CFG_RST       32'h00000000
`define CFG_RX_WMASK  32'h00000777
`define CFG_TRX_WMASK 32'h7fff3777

// Transmit/receive FIFO modes.
`define MODE_RX       2'h0
`define MODE_TX       2'h1
`define MODE_GW       2'h2

// Status register fields; count sits in bits [7:0].
`define STS_EMPTY_BIT 8
`define STS_FULL_BIT  9
`define STS_FFLG_BIT  10

// Interrupt status and mask layout.
`define IRQ_RX_LSB    0
`define IRQ_FULL_LSB  11
`define IRQ_OF_LSB    22
`define IRQ_W         25
`define IRQ_RST       25'h0000000

// Depth codes in message buffers.
`define DEPTH_C0      8'd0
`define DEPTH_C1      8'd4
`define DEPTH_C2      8'd8
`define DEPTH_C3      8'd16
`define DEPTH_C4      8'd32
`define DEPTH_C5      8'd48
`define DEPTH_C6      8'd64
`define DEPTH_C7      8'd128

`endif

/* File: can_rx_partner.sv */
// Protocol controller model that offers frames and reports transmissions.
`timescale 1ns/1ps
module can_rx_partner (
    input  wire        clk_i,
    input  wire        rx_ready_i,
    output reg         rx_valid_o = 1'b0,
    output reg  [3:0]  rx_sel_o = 4'hf,
    output reg  [31:0] rx_data_o = 32'h00000000,
    output reg  [2:0]  tx_done_o = 3'h0
);
    // A frame is held until taken; a refused one is withdrawn after a while.
    task send(input [3:0] s, input [31:0] d, output ok);
        integer k;
        begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_sel_o <= s;
            rx_data_o <= d;
            ok = 1'b0;
            for (k = 0; k < 20 && !ok; k = k + 1) begin
                @(posedge clk_i);
                ok = (rx_ready_i === 1'b1);
            end
            rx_valid_o <= 1'b0;
            rx_sel_o <= ~s;
            rx_data_o <= ~d;
        end
    endtask
    task done(input [1:0] j);
        begin
            @(posedge clk_i);
            tx_done_o <= 3'h1 << j;
            @(posedge clk_i);
            tx_done_o <= 3'h0;
        end
    endtask
endmodule // can_rx_partner

/* File: placeholder_unused_never.v */
// Empty file.
`timescale 1ns/1ps
